// File: fprp_pkg.sv
// Notes on behaviour
// RQ1 - Two-bit rounding mode: nearest, toward zero, toward minus, toward plus.
// RQ2 - Two-bit precision: extended, single, double; code 11 undefined.
// RQ3 - Round single at 24 bits, double at 53 bits, extended at 64 bits.
// RQ4 - Range check 16-bit exponent; out-of-range exponent stored in extended result.
// RQ5 - Single, toward minus, positive overflow gives exponent 00ff, top 24 ones.
// RQ6 - Infinity result has all-ones exponent and zero mantissa.
// RQ7 - Register destination uses precision field unless instruction forces single/double.
// RQ8 - Memory destinations ignore precision field and use the format's boundary.
// RQ9 - Inexact flag set whenever the rounded result differs from the intermediate.
// RQ10 - Intermediate mantissa is 67 bits: 64 kept plus guard, round, sticky.
// RQ11 - Nearest mode ties with even kept LSB are not incremented.
// RQ12 - Condition bits updated from the result after every arithmetic or move.
// RQ13 - Thirty-two conditional tests formed from the condition bits.
// RQ14 - Every result delivered as an 80-bit extended value.
// RQ15 - Too-small results set underflow and are denormalized unless that gives zero.
// RQ16 - Gross underflow returns signed zero or smallest denormal, by rounding mode.
// RQ17 - Without underflow: round, then update inexact, then check overflow.
// RQ18 - Overflow sets flag, returns signed infinity or largest normal by mode.
// RQ19 - Sticky bit is the OR of all bits right of the round bit.
// RQ20 - Mantissa bits beyond the rounding precision are forced to zero.
// RQ21 - Condition bits: negative, zero, infinity, not-a-number from the result.
// RQ22 - Toward zero truncates; directed modes bump magnitude only toward their side.
package fprp_pkg;

   typedef enum logic [1:0] {
      RND_NEAREST = 2'h0,
      RND_ZERO    = 2'h1,
      RND_MINUS   = 2'h2,
      RND_PLUS    = 2'h3
   } fprp_mode_t;

   typedef enum logic [1:0] {
      PREC_EXT = 2'h0,
      PREC_SGL = 2'h1,
      PREC_DBL = 2'h2,
      PREC_UND = 2'h3
   } fprp_prec_t;

   // Destination of the result
   typedef enum logic [1:0] {
      DST_FPREG   = 2'h0,
      DST_MEM_SGL = 2'h1,
      DST_MEM_DBL = 2'h2,
      DST_MEM_EXT = 2'h3
   } fprp_dest_t;

   typedef struct packed {
      logic               sign;
      logic signed [15:0] exp;
      logic [66:0]        mant;
      logic               zero;
      logic               inf;
      logic               nan;
   } fprp_op_t;

   typedef struct packed {
      logic        sign;
      logic [14:0] exp;
      logic [63:0] mant;
   } fprp_res_t;

   typedef struct packed {
      logic neg;
      logic zero;
      logic inf;
      logic nan;
   } fprp_cc_t;

   typedef struct packed {
      logic ovf;
      logic unf;
      logic inex;
   } fprp_flags_t;

   // Register offsets and fields
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_COND   = 4'h8;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PREC_LSB = 2;
   localparam int ST_CC_LSB     = 0;
   localparam int ST_FLAG_LSB   = 8;
   localparam int COND_TRUE_BIT = 8;
   localparam int COND_BSUN_BIT = 9;
   localparam fprp_mode_t RST_MODE = RND_NEAREST;
   localparam fprp_prec_t RST_PREC = PREC_EXT;
   localparam logic [4:0] RST_PRED = 5'h00;

   // Format figures
   localparam logic [6:0] BITS_SGL = 7'h18;
   localparam logic [6:0] BITS_DBL = 7'h35;
   localparam logic [6:0] BITS_EXT = 7'h40;
   localparam logic signed [17:0] EMIN_SGL = -18'sd126;
   localparam logic signed [17:0] EMAX_SGL = 18'sd127;
   localparam logic signed [17:0] EMIN_DBL = -18'sd1022;
   localparam logic signed [17:0] EMAX_DBL = 18'sd1023;
   localparam logic signed [17:0] EMIN_EXT = -18'sd16383;
   localparam logic signed [17:0] EMAX_EXT = 18'sd16383;
   localparam logic signed [17:0] EXT_BIAS = 18'sd16383;
   localparam logic [14:0] EXP_INF     = 15'h7fff;
   localparam logic [14:0] LARGE_X_SGL = 15'h00ff;
   localparam logic [14:0] LARGE_X_DBL = 15'h07ff;
   localparam logic [14:0] LARGE_X_EXT = 15'h7ffe;

endpackage

// File: fprp_round.sv
`timescale 1ns/1ps
`default_nettype none
module fprp_round
   import fprp_pkg::*;
(
   input  wire logic [66:0] i_mant,
   input  wire logic [6:0]  i_keep,
   input  wire fprp_mode_t  i_mode,
   input  wire logic        i_sign,
   output logic [63:0]      o_mant,
   output logic             o_carry,
   output logic             o_inexact
);

   logic [66:0] lost;
   logic [66:0] keep_mask;
   logic [67:0] unit;
   logic [67:0] sum;
   logic        lsb;
   logic        guard;
   logic        rnd;
   logic        sticky;
   logic        inc;

   // Split the mantissa at the chosen boundary
   assign lost      = i_mant << i_keep;
   assign keep_mask = ~({67{1'b1}} >> i_keep);
   assign unit      = 68'h1 << (7'd67 - i_keep);
   assign lsb       = |(i_mant & unit[66:0]);
   assign guard     = lost[66];
   assign rnd       = lost[65];
   assign sticky    = |lost[64:0]; // RQ19
   assign o_inexact = guard | rnd | sticky; // RQ9

   // Increment decision per mode
   always_comb begin
      unique case (i_mode)
         RND_NEAREST: inc = guard & (rnd | sticky | lsb); // RQ11
         RND_ZERO:    inc = 1'b0; // RQ22
         RND_MINUS:   inc = o_inexact & i_sign; // RQ22
         RND_PLUS:    inc = o_inexact & ~i_sign; // RQ22
      endcase
   end

   // Dropped bits vanish in the mask, so the tail stays zero
   assign sum     = {1'b0, i_mant & keep_mask} + (inc ? unit : 68'h0); // RQ20
   assign o_carry = sum[67];
   assign o_mant  = sum[67] ? {1'b1, 63'h0} : sum[66:3];

endmodule
`default_nettype wire

// File: fprp_cond.sv
`timescale 1ns/1ps
`default_nettype none
module fprp_cond
   import fprp_pkg::*;
(
   input  wire fprp_cc_t   i_cc,
   input  wire logic [4:0] i_pred,
   output logic            o_true,
   output logic            o_bsun
);

   // Sixteen base predicates; bit 4 marks the signaling group
   function automatic logic cond_eval(input fprp_cc_t c,
                                      input logic [3:0] p);
      logic n, z, u;
      n = c.neg;
      z = c.zero;
      u = c.nan;
      unique case (p)
         4'h0: cond_eval = 1'b0;
         4'h1: cond_eval = z;
         4'h2: cond_eval = ~(u | z | n);
         4'h3: cond_eval = z | ~(u | n);
         4'h4: cond_eval = n & ~(u | z);
         4'h5: cond_eval = z | (n & ~u);
         4'h6: cond_eval = ~(u | z);
         4'h7: cond_eval = ~u;
         4'h8: cond_eval = u;
         4'h9: cond_eval = u | z;
         4'ha: cond_eval = u | ~(n | z);
         4'hb: cond_eval = u | z | ~n;
         4'hc: cond_eval = u | (n & ~z);
         4'hd: cond_eval = u | z | n;
         4'he: cond_eval = ~z;
         4'hf: cond_eval = 1'b1;
      endcase
   endfunction

   assign o_true = cond_eval(i_cc, i_pred[3:0]); // RQ13
   assign o_bsun = i_pred[4] & i_cc.nan; // RQ13

endmodule
`default_nettype wire

// File: fprp_top.sv
`timescale 1ns/1ps
`default_nettype none
module fprp_top
   import fprp_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   // Operation from the arithmetic core
   input  wire logic        i_op_valid,
   input  wire fprp_op_t    i_op,
   input  wire fprp_dest_t  i_op_dest,
   input  wire fprp_prec_t  i_force_prec,
   input  wire logic        i_op_sets_cc,
   // Register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   // Finished result
   output logic             o_res_valid,
   output fprp_res_t        o_res,
   output fprp_flags_t      o_op_flags,
   output fprp_cc_t         o_cc
);

   ////////////////////////////////////////////////////////////////////
   // Format helpers

   function automatic logic [6:0] prec_bits(input fprp_prec_t p);
      unique case (p)
         PREC_SGL: prec_bits = BITS_SGL;
         PREC_DBL: prec_bits = BITS_DBL;
         default:  prec_bits = BITS_EXT;
      endcase
   endfunction

   function automatic logic signed [17:0] prec_emin(input fprp_prec_t p);
      unique case (p)
         PREC_SGL: prec_emin = EMIN_SGL;
         PREC_DBL: prec_emin = EMIN_DBL;
         default:  prec_emin = EMIN_EXT;
      endcase
   endfunction

   function automatic logic signed [17:0] prec_emax(input fprp_prec_t p);
      unique case (p)
         PREC_SGL: prec_emax = EMAX_SGL;
         PREC_DBL: prec_emax = EMAX_DBL;
         default:  prec_emax = EMAX_EXT;
      endcase
   endfunction

   function automatic logic [14:0] prec_large(input fprp_prec_t p);
      unique case (p)
         PREC_SGL: prec_large = LARGE_X_SGL;
         PREC_DBL: prec_large = LARGE_X_DBL;
         default:  prec_large = LARGE_X_EXT;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Software-visible state, and the last result's precision and mode kept for the checks

   fprp_mode_t  ctrl_mode;
   fprp_prec_t  ctrl_prec;
   logic [4:0]  cond_pred;
   fprp_cc_t    st_cc;
   fprp_flags_t st_flags;
   fprp_prec_t  res_prec;
   fprp_mode_t  res_mode;

   // Address decode
   wire hit_ctrl   = i_addr == ADDR_CTRL;
   wire hit_status = i_addr == ADDR_STATUS;
   wire hit_cond   = i_addr == ADDR_COND;
   wire wr_ctrl    = i_wr & hit_ctrl;
   wire wr_status  = i_wr & hit_status;
   wire wr_cond    = i_wr & hit_cond;

   ////////////////////////////////////////////////////////////////////
   // Precision and range selection

   fprp_prec_t dest_prec;
   fprp_prec_t eff_prec;

   // Memory formats ignore the field; forcing beats the field
   always_comb begin
      unique case (i_op_dest)
         DST_MEM_SGL: dest_prec = PREC_SGL; // RQ8
         DST_MEM_DBL: dest_prec = PREC_DBL; // RQ8
         DST_MEM_EXT: dest_prec = PREC_EXT; // RQ8
         DST_FPREG:   dest_prec = (i_force_prec == PREC_SGL ||
                                   i_force_prec == PREC_DBL) ?
                                  i_force_prec : ctrl_prec; // RQ7
      endcase
      // Undefined precision code falls back to extended
      eff_prec = (dest_prec == PREC_UND) ? PREC_EXT : dest_prec; // RQ2
   end

   wire [6:0]               pbits  = prec_bits(eff_prec); // RQ3
   wire logic signed [17:0] emin   = prec_emin(eff_prec);
   wire logic signed [17:0] emax   = prec_emax(eff_prec);
   wire logic signed [17:0] exp_s  = {{2{i_op.exp[15]}}, i_op.exp};
   wire logic signed [17:0] sh     = emin - exp_s;
   wire                     is_num = ~(i_op.zero | i_op.inf | i_op.nan);

   // Underflow tested before rounding
   wire unf   = is_num & (exp_s < emin); // RQ4 RQ15
   wire gross = unf & (sh >= $signed({11'h0, pbits})); // RQ16
   wire [6:0] keep = (unf & ~gross) ? pbits - sh[6:0] : pbits; // RQ15

   ////////////////////////////////////////////////////////////////////
   // Rounding

   logic [63:0] rnd_mant;
   logic        rnd_carry;
   logic        rnd_inex;

   fprp_round u_round (
      .i_mant    (i_op.mant), // RQ10
      .i_keep    (keep),
      .i_mode    (ctrl_mode), // RQ1
      .i_sign    (i_op.sign),
      .o_mant    (rnd_mant),
      .o_carry   (rnd_carry),
      .o_inexact (rnd_inex)
   );

   // Overflow only judged on the rounded exponent
   wire logic signed [17:0] e_r = exp_s + {17'h0, rnd_carry};
   wire ovf = is_num & ~unf & (e_r > emax); // RQ17 RQ18
   wire logic signed [17:0] dn_d = emin - e_r;
   wire [5:0] dn_sh = (dn_d > 18'sd0) ? dn_d[5:0] : 6'h0;
   wire logic signed [17:0] e_b = e_r + EXT_BIAS;
   wire logic signed [17:0] emin_b = emin + EXT_BIAS;

   // Direction that pushes magnitude outward for this sign
   wire away = (ctrl_mode == RND_PLUS & ~i_op.sign) |
               (ctrl_mode == RND_MINUS & i_op.sign);
   wire to_inf = (ctrl_mode == RND_NEAREST) | away;
   wire [63:0] top_ones = ~({64{1'b1}} >> pbits);
   wire [63:0] tiny     = 64'h1 << (7'd64 - pbits);

   ////////////////////////////////////////////////////////////////////
   // Result selection

   fprp_res_t   next_res;
   fprp_flags_t next_flags;
   fprp_cc_t    next_cc;

   always_comb begin
      next_res.sign   = i_op.sign;
      next_res.exp    = e_b[14:0];
      next_res.mant   = rnd_mant;
      next_flags.ovf  = ovf;
      next_flags.unf  = unf; // RQ15
      next_flags.inex = rnd_inex | ovf; // RQ9 RQ17
      if (i_op.nan) begin
         // Not-a-number payload passes untouched
         next_res.exp  = EXP_INF;
         next_res.mant = i_op.mant[66:3];
         next_flags    = '0;
      end else if (i_op.inf) begin
         next_res.exp  = EXP_INF;
         next_res.mant = 64'h0;
         next_flags    = '0;
      end else if (i_op.zero) begin
         next_res.exp  = 15'h0;
         next_res.mant = 64'h0;
         next_flags    = '0;
      end else if (gross) begin
         next_flags.inex = 1'b1;
         next_res.exp    = away ? emin_b[14:0] : 15'h0; // RQ16
         next_res.mant   = away ? tiny : 64'h0; // RQ16
      end else if (unf) begin
         // Held at the floor exponent with a shifted mantissa
         next_res.exp  = emin_b[14:0]; // RQ4
         next_res.mant = rnd_mant >> dn_sh; // RQ15
      end else if (ovf) begin
         next_res.exp  = to_inf ? EXP_INF : prec_large(eff_prec); // RQ6 RQ5
         next_res.mant = to_inf ? 64'h0 : top_ones; // RQ18 RQ5
      end
   end

   // Condition bits come from the result; the not-a-number bit from the operand flag
   always_comb begin
      next_cc.neg  = next_res.sign; // RQ21
      next_cc.nan  = i_op.nan; // RQ21
      next_cc.inf  = ~i_op.nan & (next_res.exp == EXP_INF); // RQ21
      next_cc.zero = ~i_op.nan & ~next_cc.inf &
                     (next_res.mant == 64'h0); // RQ21
   end

   ////////////////////////////////////////////////////////////////////
   // Result registers

   // Delivered as one 80-bit extended word
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_res_valid <= 1'b0;
         o_res       <= '0;
         o_op_flags  <= '0;
         res_prec    <= PREC_EXT;
         res_mode    <= RND_NEAREST;
      end else begin
         o_res_valid <= i_op_valid;
         if (i_op_valid) begin
            o_res      <= next_res; // RQ14
            o_op_flags <= next_flags;
            res_prec   <= eff_prec;
            res_mode   <= ctrl_mode;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register file

   // Control word steers rounding and precision
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ctrl_mode <= RST_MODE;
         ctrl_prec <= RST_PREC;
         cond_pred <= RST_PRED;
      end else begin
         if (wr_ctrl) begin
            ctrl_mode <= fprp_mode_t'(i_wdata[CTRL_MODE_LSB +: 2]); // RQ1
            ctrl_prec <= fprp_prec_t'(i_wdata[CTRL_PREC_LSB +: 2]); // RQ2
         end
         if (wr_cond) begin
            cond_pred <= i_wdata[4:0];
         end
      end
   end

   // Sticky flags: a new event wins over a clear in the same cycle
   wire [2:0] flag_clr = wr_status ? i_wdata[ST_FLAG_LSB +: 3] : 3'h0;
   wire [2:0] flag_set = i_op_valid ? next_flags : 3'h0;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st_flags <= '0;
         st_cc    <= '0;
         o_cc     <= '0;
      end else begin
         st_flags <= (st_flags & ~flag_clr) | flag_set; // RQ9
         if (i_op_valid && i_op_sets_cc) begin
            st_cc <= next_cc; // RQ12
            o_cc  <= next_cc; // RQ12
         end
      end
   end

   logic cond_true;
   logic cond_bsun;

   fprp_cond u_cond (
      .i_cc   (st_cc),
      .i_pred (cond_pred),
      .o_true (cond_true),
      .o_bsun (cond_bsun)
   );

   // Read mux; unmapped addresses read zero
   wire [31:0] rd_ctrl   = {28'h0, ctrl_prec, ctrl_mode};
   wire [31:0] rd_status = {21'h0, st_flags, 4'h0, st_cc};
   wire [31:0] rd_cond   = {22'h0, cond_bsun, cond_true, 3'h0, cond_pred};
   wire [31:0] rd_mux    = hit_ctrl   ? rd_ctrl   :
                           hit_status ? rd_status :
                           hit_cond   ? rd_cond   : 32'h0;

   // Data stand only in the cycle after the strobe
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   // Extended, in-range operation under a fixed mode
   sequence s_ext_op(fprp_mode_t m);
      i_op_valid && is_num && !unf && !ovf &&
      eff_prec == PREC_EXT && ctrl_mode == m && !wr_ctrl;
   endsequence

   sequence s_tie_even;
      i_op.mant[3:0] == 4'h4;
   endsequence

   chk_tie_to_even: assert property ( // RQ11
      s_ext_op(RND_NEAREST) ##0 s_tie_even |=>
      o_res.mant == $past(i_op.mant[66:3]))
      else $error("tie case was rounded away from even");

   chk_zero_trunc: assert property ( // RQ22
      s_ext_op(RND_ZERO) |=> o_res.mant == $past(i_op.mant[66:3]) &&
      o_res.exp == $past(e_b[14:0]))
      else $error("toward-zero result not truncated");

   chk_inexact_seen: assert property ( // RQ9
      s_ext_op(RND_NEAREST) ##0 (i_op.mant[2:0] != 3'h0) |=>
      o_op_flags.inex && st_flags.inex)
      else $error("inexact not reported");

   chk_flag_holds: assert property ( // RQ9
      st_flags.unf && !(wr_status && i_wdata[ST_FLAG_LSB + 1]) |=>
      st_flags.unf)
      else $error("underflow flag lost without a clear");

   chk_single_tail: assert property ( // RQ20
      o_res_valid && res_prec == PREC_SGL && !o_cc.nan |->
      o_res.mant[39:0] == 40'h0)
      else $error("bits below single boundary not zero");

   chk_ovf_infinity: assert property ( // RQ6
      o_res_valid && o_op_flags.ovf && res_mode == RND_NEAREST |->
      o_res.exp == EXP_INF && o_res.mant == 64'h0 &&
      (o_cc.inf || !$past(i_op_sets_cc)))
      else $error("nearest overflow did not give infinity");

   chk_sgl_rm_large: assert property ( // RQ5
      o_res_valid && o_op_flags.ovf && res_mode == RND_MINUS &&
      res_prec == PREC_SGL && !o_res.sign |->
      o_res.exp == LARGE_X_SGL && o_res.mant == 64'hffffff0000000000)
      else $error("largest single value wrong");

   chk_gross_unf: assert property ( // RQ16
      i_op_valid && gross && !wr_ctrl &&
      (ctrl_mode == RND_ZERO || (ctrl_mode == RND_PLUS && i_op.sign) ||
       (ctrl_mode == RND_MINUS && !i_op.sign)) |=>
      o_op_flags.unf && o_res.mant == 64'h0 &&
      o_res.sign == $past(i_op.sign))
      else $error("gross underflow not signed zero");

   chk_cc_zero: assert property ( // RQ21
      i_op_valid && i_op_sets_cc && i_op.zero |=>
      o_cc.zero && !o_cc.inf && o_cc.neg == $past(i_op.sign))
      else $error("zero condition bits wrong");

   chk_read_timing: assert property (
      i_rd && hit_ctrl && !wr_ctrl |=> o_rdata[3:0] ==
      {$past(ctrl_prec), $past(ctrl_mode)} ##1
      ($past(i_rd) || o_rdata == 32'h0))
      else $error("read data not one cycle late");

endmodule
`default_nettype wire

// File: test_fp_round_postprocess.sv
`timescale 1ns/1ps
`default_nettype none
module test_fp_round_postprocess
   import fprp_pkg::*;
   ;
   logic        clk;
   logic        srst;
   logic        op_valid;
   logic        sets_cc;
   logic        wr;
   logic        rd;
   fprp_op_t    op;
   fprp_dest_t  dest;
   fprp_prec_t  frc;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        res_valid;
   fprp_res_t   res;
   fprp_flags_t flg;
   fprp_cc_t    cc;
   int          n_fail;
   int          cmp_count;
   int          cyc = 0;
   int          seed;
   int          it;
   int          p;
   logic [64:0] ref_v;
   logic [31:0] rv;
   logic [3:0]  exp_cc;
   logic [66:0] m;
   logic        sg;
   logic        cc_on;
   logic [1:0]  md;
   logic signed [15:0] e;
   fprp_dest_t  dv;
   fprp_prec_t  fv;

   ////////////////////////////////////////////////////////////////////////
   // Clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   fprp_top i_fprp_top (
      .i_sys_clk   (clk),
      .i_srst      (srst),
      .i_op_valid  (op_valid),
      .i_op        (op),
      .i_op_dest   (dest),
      .i_force_prec(frc),
      .i_op_sets_cc(sets_cc),
      .i_addr      (addr),
      .i_wdata     (wdata),
      .i_wr        (wr),
      .i_rd        (rd),
      .o_rdata     (rdata),
      .o_res_valid (res_valid),
      .o_res       (res),
      .o_op_flags  (flg),
      .o_cc        (cc)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared compare, wide enough for exponent and mantissa together
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Register port cycles, strobes one cycle long
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // One operation; result must follow exactly one cycle later
   task automatic do_op(input logic s, input logic signed [15:0] x,
                        input logic [66:0] mm, input fprp_dest_t d,
                        input fprp_prec_t f, input logic c);
      @(posedge clk);
      op_valid <= 1'b1;
      op <= '{s, x, mm, 1'b0, 1'b0, 1'b0};
      dest <= d;
      frc <= f;
      sets_cc <= c;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk(res_valid, 1'b1);
   endtask

   task automatic expect_res(input logic [14:0] x, input logic [63:0] mm,
                             input logic [2:0] f);
      chk({res.exp, res.mant}, {x, mm});
      chk(flg, f);
   endtask

   // Reference rounding of a normalized mantissa at pb kept bits
   function automatic logic [64:0] round_ref(input logic [66:0] mm,
                                             input int pb,
                                             input logic [1:0] mo,
                                             input logic s);
      int         sh;
      logic [63:0] k;
      logic       g;
      logic       st;
      logic       inc;
      sh = 67 - pb;
      k = 64'(mm >> sh);
      g = mm[sh-1];
      st = |(mm & ((67'h1 << (sh - 1)) - 67'h1));
      case (mo)
         2'h0: inc = g & (st | k[0]);
         2'h1: inc = 1'b0;
         2'h2: inc = (g | st) & s;
         default: inc = (g | st) & ~s;
      endcase
      k = (k + 64'(inc)) << (64 - pb);
      return {g | st, k};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc > 8000) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      seed = 32'hd76d;
      n_fail = 0;
      cmp_count = 0;
      srst = 1'b1;
      op_valid = 1'b0;
      op = '0;
      dest = DST_FPREG;
      frc = PREC_EXT;
      sets_cc = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      exp_cc = 4'h0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      reg_rd(ADDR_CTRL, rv);
      chk(rv, 32'h0);
      reg_wr(ADDR_CTRL, 32'h6);
      reg_rd(ADDR_CTRL, rv);
      chk(rv, 32'h6);
      reg_rd(4'hc, rv);
      chk(rv, 32'h0);
      // Sweep all modes; field says single so overrides and memory show
      for (it = 0; it < 160; it++) begin
         md = 2'(it / 40);
         if (it % 40 == 0) reg_wr(ADDR_CTRL, {28'h0, 2'h1, md});
         m = {2'b10, 33'($random(seed)), 32'($random(seed))};
         sg = 1'($random(seed));
         cc_on = 1'($random(seed));
         e = 16'($random(seed) % 100);
         case (it % 4)
            0: begin dv = DST_FPREG; fv = PREC_EXT; p = 24; end
            1: begin dv = DST_FPREG; fv = PREC_DBL; p = 53; end
            2: begin dv = DST_MEM_EXT; fv = PREC_UND; p = 64; end
            default: begin dv = DST_MEM_DBL; fv = PREC_SGL; p = 53; end
         endcase
         ref_v = round_ref(m, p, md, sg);
         do_op(sg, e, m, dv, fv, cc_on);
         if (cc_on) exp_cc = {sg, 3'h0};
         expect_res(15'(e + 16'sd16383), ref_v[63:0], {2'b00, ref_v[64]});
         chk(res.sign, sg);
         chk(cc, exp_cc);
      end
      // Ties in nearest: even stays, odd steps up
      reg_wr(ADDR_CTRL, 32'h0);
      do_op(1'b0, 16'sd0, 67'h40000000000000004, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h3fff, 64'h8000000000000000, 3'h1);
      do_op(1'b0, 16'sd0, 67'h4000000000000000c, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h3fff, 64'h8000000000000002, 3'h1);
      // Sticky flags, then write one to clear
      reg_rd(ADDR_STATUS, rv);
      chk(rv, 32'h100);
      reg_wr(ADDR_STATUS, 32'h700);
      reg_rd(ADDR_STATUS, rv);
      chk(rv, 32'h0);
      // Overflow: largest single toward minus, infinity in nearest
      reg_wr(ADDR_CTRL, 32'h6);
      do_op(1'b0, 16'sd200, {2'b10, 65'h0}, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h00ff, 64'hffffff0000000000, 3'h5);
      reg_rd(ADDR_STATUS, rv);
      chk(rv, 32'h500);
      reg_wr(ADDR_CTRL, 32'h4);
      do_op(1'b1, 16'sd200, {2'b10, 65'h0}, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h7fff, 64'h0, 3'h5);
      chk(cc, 4'ha);
      reg_wr(ADDR_CTRL, 32'h7);
      do_op(1'b1, 16'sd200, {2'b10, 65'h0}, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h00ff, 64'hffffff0000000000, 3'h5);
      // Underflow: mild denormal, gross toward and away from zero
      do_op(1'b0, -16'sd127, {2'b10, 65'h0}, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h3f81, 64'h4000000000000000, 3'h2);
      do_op(1'b0, -16'sd300, {2'b10, 65'h0}, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h3f81, 64'h0000010000000000, 3'h3);
      do_op(1'b1, -16'sd300, {2'b10, 65'h0}, DST_FPREG, PREC_EXT, 1'b1);
      expect_res(15'h0, 64'h0, 3'h3);
      chk(cc, 4'hc);
      // Zero operand, then predicates read back over the new bits
      @(posedge clk);
      op_valid <= 1'b1;
      op <= '{1'b0, 16'sd5, 67'h0, 1'b1, 1'b0, 1'b0};
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      expect_res(15'h0, 64'h0, 3'h0);
      chk(cc, 4'h4);
      reg_wr(ADDR_COND, 32'h13);
      reg_rd(ADDR_COND, rv);
      chk(rv, 32'h113);
      reg_wr(ADDR_COND, 32'h04);
      reg_rd(ADDR_COND, rv);
      chk(rv, 32'h004);
      // Reset in mid-run clears control and condition bits
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      reg_rd(ADDR_CTRL, rv);
      chk(rv, 32'h0);
      chk(cc, 4'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
